// ---- rtl/prt_pkg.sv ----
package prt_pkg;

    // ----------------------------------------------------------------
    // Clock and tick timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLK_PS = 1000000 / CLK_MHZ;
    localparam int unsigned BASE_TICK_NS = 15;
    localparam int unsigned SLOW_TICK_NS = 20;
    localparam int unsigned BASE_TICK_PS = BASE_TICK_NS * 1000;
    localparam int unsigned SLOW_TICK_PS = SLOW_TICK_NS * 1000;
    localparam int unsigned ACC_W = 16;

    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;
    localparam logic [APB_AW-1:0] ADDR_SETUP = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_PRESCALE = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_RELOAD = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_EVENT = 8'h0C;
    localparam logic [APB_AW-1:0] ADDR_MASK = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_COUNT = 8'h14;

    // ----------------------------------------------------------------
    // Setup register fields
    // ----------------------------------------------------------------
    localparam int unsigned CFG_W = 5;
    localparam int unsigned CFG_ADJ_LSB = 0;
    localparam int unsigned CFG_ADJ_W = 2;
    localparam int unsigned CFG_SPARE_BIT = 2;
    localparam int unsigned CFG_PAUSE_BIT = 3;
    localparam int unsigned CFG_SLOW_BIT = 4;

    // ----------------------------------------------------------------
    // Event flags and reset values
    // ----------------------------------------------------------------
    localparam int unsigned EVT_W = 1;
    localparam int unsigned EVT_ROLL_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
    localparam logic [EVT_W-1:0] EVT_RST = 1'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 1'h0;

endpackage

// ---- rtl/prt_tick_gen.sv ----
`timescale 1ns/1ps
module prt_tick_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic slow,
    // Tick out
    output logic tick
);
    import prt_pkg::*;

    logic [ACC_W-1:0] acc;
    wire [ACC_W-1:0] period;
    wire [ACC_W-1:0] acc_next;
    wire hit;

    // ----------------------------------------------------------------
    // Fractional tick accumulator
    // ----------------------------------------------------------------
    // selects tick period
    assign period = slow ? ACC_W'(SLOW_TICK_PS) : ACC_W'(BASE_TICK_PS);
    assign acc_next = acc + ACC_W'(CLK_PS);
    assign hit = acc_next >= period;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= hit ? acc_next - period : acc_next;
            tick <= hit;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_slow_tick_gap: assert property (
        (tick && slow) |=> (!tick || !slow) [*4])
        else $error("slow tick came sooner than five cycles");

    a_base_tick_gap: assert property (
        tick |=> !tick [*2])
        else $error("base tick came sooner than three cycles");

endmodule

// ---- rtl/prt_prescaler.sv ----
`timescale 1ns/1ps
module prt_prescaler #(
    parameter int unsigned PRE_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [PRE_W-1:0] divide,
    // Prescaled tick
    output logic ptick
);
    import prt_pkg::*;

    logic [PRE_W-1:0] cnt;
    wire wrap;

    // ----------------------------------------------------------------
    // Divide by value plus one
    // ----------------------------------------------------------------
    // wraps after divide plus one
    assign wrap = cnt >= divide;
    assign ptick = tick && run && wrap;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (restart) begin
            cnt <= '0;
        end else if (tick && run) begin
            cnt <= wrap ? '0 : cnt + PRE_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_zero_passes_tick: assert property (
        (divide == '0 && tick && run) |-> ptick)
        else $error("zero prescale did not pass the tick");

endmodule

// ---- rtl/prt_timer.sv ----
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module prt_timer #(
    parameter int unsigned PRE_W = 16,
    parameter int unsigned CNT_W = 16
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [prt_pkg::APB_AW-1:0] PADDR,
    input wire logic [prt_pkg::APB_DW-1:0] PWDATA,
    output logic [prt_pkg::APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Interrupt
    output logic IRQ
);
    import prt_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [CFG_W-1:0] cfg;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] count;
    logic running;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [CNT_W-1:0] next_count;
    logic next_running;
    logic tick;
    logic ptick;

    function automatic logic [CNT_W-1:0] eff_reload(
        input logic [CNT_W-1:0] base,
        input logic [CFG_ADJ_W-1:0] adj_bits
    );
        return base + CNT_W'(adj_bits);
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire setup_ph = PSEL && !PENABLE;
    wire wr = PSEL && PENABLE && PWRITE;
    wire sel_cfg = PADDR == ADDR_SETUP;
    wire sel_pre = PADDR == ADDR_PRESCALE;
    wire sel_reload = PADDR == ADDR_RELOAD;
    wire sel_evt = PADDR == ADDR_EVENT;
    wire sel_mask = PADDR == ADDR_MASK;
    wire sel_cnt = PADDR == ADDR_COUNT;
    wire mapped = sel_cfg || sel_pre || sel_reload || sel_evt || sel_mask
        || sel_cnt;
    wire wr_cfg = wr && sel_cfg;
    wire wr_pre = wr && sel_pre;
    wire wr_reload = wr && sel_reload;
    wire wr_evt = wr && sel_evt;
    wire wr_mask = wr && sel_mask;

    wire [APB_DW-1:0] rd_data =
        sel_cfg ? APB_DW'(cfg) :
        sel_pre ? APB_DW'(pre) :
        sel_reload ? APB_DW'(reload) :
        sel_evt ? APB_DW'(evt) :
        sel_mask ? APB_DW'(mask) :
        sel_cnt ? APB_DW'(count) : '0;

    assign PREADY = 1'b1;

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (setup_ph) begin
            PRDATA <= rd_data;
            PSLVERR <= !mapped;
        end
    end

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    wire [CFG_ADJ_W-1:0] adj = cfg[CFG_ADJ_LSB +: CFG_ADJ_W];
    wire paused = cfg[CFG_PAUSE_BIT];
    wire slow = cfg[CFG_SLOW_BIT];
    wire run = running && !paused;

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            cfg <= CFG_RST;
            pre <= '0;
            reload <= '0;
            mask <= MASK_RST;
        end else begin
            if (wr_cfg) begin
                cfg <= PWDATA[CFG_W-1:0];
            end
            if (wr_pre) begin
                pre <= PWDATA[PRE_W-1:0];
            end
            if (wr_reload) begin
                reload <= PWDATA[CNT_W-1:0];
            end
            if (wr_mask) begin
                mask <= PWDATA[EVT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Tick source and prescaler
    // ----------------------------------------------------------------
    prt_tick_gen u_tick (
        .clk(MCLK),
        .rst_n(RESETN),
        .slow(slow),
        .tick(tick)
    );

    prt_prescaler #(
        .PRE_W(PRE_W)
    ) u_pre (
        .clk(MCLK),
        .rst_n(RESETN),
        .tick(tick),
        .run(run),
        .restart(wr_pre || wr_reload),
        .divide(pre),
        .ptick(ptick)
    );

    // ----------------------------------------------------------------
    // Reload counter
    // ----------------------------------------------------------------
    // one step per prescaled tick
    wire rollover = ptick && (count == CNT_W'(1)) && !wr_reload;
    wire [CNT_W-1:0] new_load = eff_reload(PWDATA[CNT_W-1:0], adj);
    wire [CNT_W-1:0] roll_load = eff_reload(reload, adj);

    always_comb begin
        next_count = count;
        next_running = running;
        if (wr_reload) begin
            next_count = new_load;
            next_running = new_load != '0;
        end else if (rollover) begin
            next_count = roll_load;
            next_running = roll_load != '0;
        end else if (ptick) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            count <= '0;
            running <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
        end
    end

    // ----------------------------------------------------------------
    // Event flag and interrupt
    // ----------------------------------------------------------------
    wire [EVT_W-1:0] evt_clr = wr_evt ? PWDATA[EVT_W-1:0] : '0;
    wire [EVT_W-1:0] evt_set = EVT_W'(rollover) << EVT_ROLL_BIT;

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            evt <= EVT_RST;
        end else begin
            evt <= (evt & ~evt_clr) | evt_set;
        end
    end

    assign IRQ = |(evt & mask);

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    logic [31:0] roll_ticks;
    logic [CNT_W-1:0] period_len;
    logic clean;

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            roll_ticks <= '0;
            period_len <= '0;
            clean <= 1'b0;
        end else begin
            if (wr_reload || rollover) begin
                roll_ticks <= '0;
            end else if (tick && run) begin
                roll_ticks <= roll_ticks + 32'h1;
            end
            if (wr_reload) begin
                period_len <= new_load;
            end else if (rollover) begin
                period_len <= roll_load;
            end
            if (wr_pre) begin
                clean <= 1'b0;
            end else if (wr_reload || rollover) begin
                clean <= 1'b1;
            end
        end
    end

    wire [31:0] want_ticks = (32'(pre) + 32'h1) * 32'(period_len);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    sequence s_clean_roll;
        rollover && clean && !wr_pre;
    endsequence

    sequence s_resume;
        $fell(paused) && running && !wr_reload;
    endsequence

    a_period_product: assert property (
        s_clean_roll |-> roll_ticks + 32'h1 == want_ticks)
        else $error("rollover period is not prescale times reload");

    a_roll_on_tick: assert property (
        rollover |-> tick && run && u_pre.wrap)
        else $error("rollover without an enabled prescaled tick");

    a_reload_loads_now: assert property (
        wr_reload |=> count == $past(new_load)
            && running == ($past(new_load) != '0))
        else $error("reload write did not load the counter");

    a_roll_reloads: assert property (
        rollover |=> count == $past(roll_load) && evt[EVT_ROLL_BIT])
        else $error("rollover did not reload and flag");

    a_adjust_deferred: assert property (
        (wr_cfg && !rollover && !wr_reload) |=>
            count == $past(count) || count == $past(count) - CNT_W'(1))
        else $error("adjust bits changed the count before rollover");

    a_adjust_value: assert property (
        rollover |-> roll_load == reload + CNT_W'(adj))
        else $error("effective reload is not reload plus adjust");

    a_adjust_two: assert property (
        (rollover && reload == CNT_W'(16'h41) && adj == 2'h2)
            |=> count == CNT_W'(16'h43))
        else $error("adjust two did not give a count of 67");

    a_adjust_one: assert property (
        (rollover && reload == CNT_W'(16'h41) && adj == 2'h1)
            |=> count == CNT_W'(16'h42))
        else $error("adjust one did not give a count of 66");

    a_flag_pending: assert property (
        (evt[EVT_ROLL_BIT] && !(wr_evt && PWDATA[EVT_ROLL_BIT]))
            |=> evt[EVT_ROLL_BIT])
        else $error("rollover flag dropped without a clear");

    a_irq_follows: assert property (
        $rose(evt[EVT_ROLL_BIT]) && mask[EVT_ROLL_BIT] |-> IRQ)
        else $error("unmasked rollover flag did not raise the interrupt");

    a_pause_hold: assert property (
        (paused && !wr_reload) [*2] |-> count == $past(count))
        else $error("count moved while paused");

    a_resume_held: assert property (
        s_resume |-> count == $past(count) && running)
        else $error("resume reloaded or stopped the counter");

    a_resume_counts: assert property (
        (s_resume && pre == '0 && count > CNT_W'(1))
            |-> ##[1:6] count != $past(count))
        else $error("count did not move after resume");

endmodule

// ---- testbench/test_prescaled_reload_timer.sv ----
`timescale 1ns/1ps
module test_prescaled_reload_timer;
    import prt_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int LIMIT = 20000;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    logic [APB_DW-1:0] rd;
    logic er;
    logic [APB_DW-1:0] held;
    int t0;
    int t1;
    int t2;
    int e;
    logic [APB_DW-1:0] cfgs [5] = '{32'h02, 32'h01, 32'h10, 32'h13, 32'h04};
    logic [APB_DW-1:0] pres [5] = '{32'h00, 32'h00, 32'h01, 32'h02, 32'h19};
    logic [APB_DW-1:0] rls [5] = '{32'h41, 32'h41, 32'h07, 32'h04, 32'h02};
    logic [APB_AW-1:0] addrs [6] = '{ADDR_SETUP, ADDR_PRESCALE, ADDR_RELOAD,
        ADDR_EVENT, ADDR_MASK, ADDR_COUNT};

`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("ERROR %0t got %0h exp %0h", $time, got, exp); \
        end \
    end

    // ----------------------------------------------------------------
    // Design and clock
    // ----------------------------------------------------------------
    prt_timer #(.PRE_W(16), .CNT_W(16)) dut (
        .MCLK(mclk),
        .RESETN(resetn),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .IRQ(irq)
    );

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                       input logic [APB_DW-1:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [APB_AW-1:0] a,
                         input logic [APB_DW-1:0] x, input logic ex);
        apb(1'b0, a, '0);
        `CHK(rd, x)
        `CHK(er, ex)
    endtask

    // Wait for the interrupt, note the cycle, clear the flag
    task automatic wait_roll(output int t);
        int k;
        k = 0;
        @(posedge mclk);
        while (irq !== 1'b1 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        t = cyc;
        `CHK(irq, 1'b1)
        wr(ADDR_EVENT, 32'h01);
    endtask

    // Accept a measured time within a tolerance of the expected one
    function automatic int snap(input int got, input int x, input int tol);
        return (got >= x - tol && got <= x + tol) ? x : got;
    endfunction

    function automatic int exp_ns(input logic [APB_DW-1:0] c,
                                  input logic [APB_DW-1:0] p,
                                  input logic [APB_DW-1:0] r);
        int tk;
        tk = c[CFG_SLOW_BIT] ? SLOW_TICK_NS : BASE_TICK_NS;
        return (int'(p) + 1) * (int'(r) + int'(c[1:0])) * tk;
    endfunction

    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        `CHK(irq, 1'b0)
        foreach (addrs[i]) rdchk(addrs[i], '0, 1'b0);
        rdchk(8'h18, '0, 1'b1);
        wr(8'h18, 32'hFFFF);
        `CHK(er, 1'b1)
        // masked flag, sticky level, one clears
        wr(ADDR_PRESCALE, 32'h00);
        wr(ADDR_RELOAD, 32'h05);
        repeat (40) @(posedge mclk);
        `CHK(irq, 1'b0)
        rdchk(ADDR_EVENT, 32'h01, 1'b0);
        wr(ADDR_RELOAD, 32'h00);
        wr(ADDR_MASK, 32'h01);
        @(posedge mclk);
        `CHK(irq, 1'b1)
        repeat (30) @(posedge mclk);
        `CHK(irq, 1'b1)
        wr(ADDR_EVENT, 32'h01);
        @(posedge mclk);
        `CHK(irq, 1'b0)
        rdchk(ADDR_EVENT, 32'h00, 1'b0);
        wr(ADDR_SETUP, 32'h18);
        rdchk(ADDR_SETUP, 32'h18, 1'b0);
        wr(ADDR_RELOAD, 32'h30);
        rdchk(ADDR_COUNT, 32'h30, 1'b0);
        wr(ADDR_COUNT, 32'h1234);
        repeat (20) @(posedge mclk);
        rdchk(ADDR_COUNT, 32'h30, 1'b0);
        wr(ADDR_SETUP, 32'h10);
        repeat (50) @(posedge mclk);
        wr(ADDR_SETUP, 32'h18);
        apb(1'b0, ADDR_COUNT, '0);
        held = rd;
        `CHK(held < 32'h30 && held > 32'h20, 1'b1)
        repeat (40) @(posedge mclk);
        rdchk(ADDR_COUNT, held, 1'b0);
        wr(ADDR_SETUP, 32'h10);
        t0 = cyc;
        wait_roll(t1);
        e = int'(held) * SLOW_TICK_NS;
        `CHK(snap((t1 - t0) * 4, e, 24), e)
        foreach (cfgs[i]) begin
            wr(ADDR_SETUP, cfgs[i]);
            wr(ADDR_PRESCALE, pres[i]);
            rdchk(ADDR_PRESCALE, pres[i], 1'b0);
            wr(ADDR_RELOAD, rls[i]);
            wr(ADDR_EVENT, 32'h01);
            wait_roll(t0);
            wait_roll(t1);
            e = exp_ns(cfgs[i], pres[i], rls[i]);
            `CHK(snap((t1 - t0) * 4, e, 8), e)
        end
        wr(ADDR_SETUP, 32'h02);
        wr(ADDR_PRESCALE, 32'h00);
        wr(ADDR_RELOAD, 32'h41);
        wr(ADDR_EVENT, 32'h01);
        wait_roll(t0);
        wr(ADDR_SETUP, 32'h01);
        wait_roll(t1);
        wait_roll(t2);
        `CHK(snap((t1 - t0) * 4, 1005, 8), 1005)
        `CHK(snap((t2 - t1) * 4, 990, 8), 990)
        wr(ADDR_SETUP, 32'h07);
        wr(ADDR_PRESCALE, 32'h19);
        wr(ADDR_RELOAD, 32'h15);
        repeat (200) @(posedge mclk);
        wr(ADDR_SETUP, 32'h0F);
        apb(1'b0, ADDR_COUNT, '0);
        held = rd;
        `CHK(held < 32'h18 && held > 32'h10, 1'b1)
        repeat (40) @(posedge mclk);
        rdchk(ADDR_COUNT, held, 1'b0);
        wr(ADDR_SETUP, 32'h07);
        wr(ADDR_PRESCALE, 32'h19);
        wr(ADDR_EVENT, 32'h01);
        wait_roll(t0);
        wait_roll(t1);
        e = exp_ns(32'h07, 32'h19, 32'h15);
        `CHK(snap((t1 - t0) * 4, e, 8), e)
        summarize();
    end

endmodule
